// [bench/fault_monitor_checker.sv]
// Port-level assertions for the fault monitor
`timescale 1ns/1ps
module fault_monitor_checker (
	// Clock and reset
	input wire        clk,
	input wire        nrst,
	// Register bus
	input wire [3:0]  address,
	input wire        read,
	input wire        write,
	input wire [31:0] writedata,
	input wire        waitrequest,
	// Events and outputs
	input wire        sensor_fatal,
	input wire        fetch_compare_fail,
	input wire        ee_double_read_en,
	input wire        irq,
	input wire        security_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Bus steps and reset pulse shape
	sequence s_req; (read || write) && waitrequest; endsequence
	sequence s_ans; !waitrequest; endsequence
	sequence s_pulse; security_reset[*8] ##1 !security_reset; endsequence
	AST_ANSWER: assert property (s_req |=> s_ans)
		else $error("no answer one cycle after request");
	AST_STAND: assert property (s_ans |=> waitrequest)
		else $error("answer held past one cycle");
	AST_IDLE: assert property (!read && !write |=> waitrequest)
		else $error("answer without request");
	AST_FATAL: assert property ($rose(sensor_fatal) |-> ##[1:6] security_reset)
		else $error("fatal sensor without reset");
	AST_PULSE: assert property ($rose(security_reset) |-> s_pulse)
		else $error("reset pulse not eight cycles");
	AST_FETCH: assert property (fetch_compare_fail |-> ##[1:6] security_reset)
		else $error("fetch mismatch without reset");
	AST_DBL: assert property (write && !waitrequest && address == 4'h0
		|=> ##1 ee_double_read_en == $past(writedata[1], 2))
		else $error("double read enable not following control");
	AST_IRQ: assert property ($fell(security_reset) |-> ##[0:2] !irq)
		else $error("interrupt survives reset");
endmodule

bind fault_monitor_exception_reset fault_monitor_checker fault_monitor_checker_inst (
	.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
	.writedata(writedata), .waitrequest(waitrequest),
	.sensor_fatal(sensor_fatal), .fetch_compare_fail(fetch_compare_fail),
	.ee_double_read_en(ee_double_read_en), .irq(irq),
	.security_reset(security_reset));

// [bench/fault_monitor_exception_reset_test.sv]
// Self-checking bench for the fault monitor
`timescale 1ns/1ps
`include "fault_monitor_defines.vh"
module fault_monitor_exception_reset_test;
	reg         clk, nrst, read, write, sensor_out_of_range, sensor_fatal;
	reg         ram_read, ram_write, ee_write_active, ee_hv_ok, ee_ecc_error;
	reg         fetch_compare_fail, bignum_access;
	reg  [3:0]  address;
	reg  [31:0] writedata, rdata;
	reg  [7:0]  ram_addr, ram_wdata;
	reg  [1:0]  cpu_mode;
	reg  [15:0] stack_pointer;
	wire [31:0] readdata;
	wire [7:0]  ram_rdata;
	wire        waitrequest, ee_double_read_en, irq, security_reset;
	integer     fail_count, num_checks, i, n, k;
	fault_monitor_exception_reset fault_monitor_exception_reset_inst (
		.clk(clk), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sensor_out_of_range(sensor_out_of_range),
		.sensor_fatal(sensor_fatal), .ram_read(ram_read),
		.ram_write(ram_write), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_rdata(ram_rdata), .cpu_mode(cpu_mode),
		.stack_pointer(stack_pointer), .ee_write_active(ee_write_active),
		.ee_hv_ok(ee_hv_ok), .ee_ecc_error(ee_ecc_error),
		.ee_double_read_en(ee_double_read_en),
		.fetch_compare_fail(fetch_compare_fail),
		.bignum_access(bignum_access), .irq(irq),
		.security_reset(security_reset));
	// 20 MHz clock
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// Verdict
	task close_out;
		begin
			$display("checks %0d mismatches %0d", num_checks, fail_count);
			if (fail_count == 0 && num_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// Compare and count
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("wrong value %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// One transfer, held until waitrequest is sampled low
	task bus(input w, input [3:0] a, input [31:0] d);
		begin
			address <= a;
			writedata <= d;
			read <= !w;
			write <= w;
			n = 0;
			do begin
				@(posedge clk);
				n = n + 1;
			end while (waitrequest !== 1'b0 && n < 20);
			rdata = readdata;
			read <= 0;
			write <= 0;
			if (n >= 20) begin
				fail_count = fail_count + 1;
				close_out;
			end
			@(posedge clk);
		end
	endtask
	// Preload RAM, read back, let the scrubber run
	task t_ram;
		begin
			for (i = 0; i < 256; i = i + 1) begin
				ram_write <= 1;
				ram_addr <= i[7:0];
				ram_wdata <= i[7:0] ^ 8'h5a;
				@(posedge clk);
			end
			ram_write <= 0;
			ram_read <= 1;
			ram_addr <= 8'h33;
			@(posedge clk);
			ram_read <= 0;
			@(posedge clk);
			chk("ram", 8'h69, ram_rdata);
			repeat (600) @(posedge clk);
			chk("scrub", 0, security_reset);
		end
	endtask
	// One exception: interrupt, reason, hold, clear
	task t_exc(input integer b);
		begin
			bus(1, `OFS_EXC_MASK, 32'h1f);
			bus(1, `OFS_CTRL, 32'hc);
			bus(1, `OFS_SP_HIGH, 32'h100);
			case (b)
				0: sensor_out_of_range <= 1;
				1: stack_pointer <= 16'h200;
				2: ee_ecc_error <= 1;
				default: bignum_access <= 1;
			endcase
			@(posedge clk);
			ee_ecc_error <= 0;
			bignum_access <= 0;
			for (i = 0; i < 20 && irq !== 1'b1; i = i + 1) @(posedge clk);
			sensor_out_of_range <= 0;
			stack_pointer <= 16'h80;
			chk("irq", 1, irq);
			repeat (4) @(posedge clk);
			bus(0, `OFS_EXC_STATUS, 0);
			chk("reason", 1 << b, rdata);
			bus(0, `OFS_EXC_STATUS, 0);
			chk("held", 1 << b, rdata);
			bus(1, `OFS_EXC_STATUS, 1 << b);
			bus(0, `OFS_EXC_STATUS, 0);
			chk("cleared", 0, rdata);
		end
	endtask
	// Forced reset: pulse length and sticky cause
	task t_rst(input integer b, input [31:0] c);
		begin
			case (b)
				0: sensor_fatal <= 1;
				1: fetch_compare_fail <= 1;
				default: begin
					bus(1, `OFS_WDT_LOAD, 32'h20);
					bus(1, `OFS_CTRL, 32'h1);
				end
			endcase
			@(posedge clk);
			fetch_compare_fail <= 0;
			for (i = 0; i < 200 && security_reset !== 1'b1; i = i + 1)
				@(posedge clk);
			sensor_fatal <= 0;
			for (n = 0; n < 20 && security_reset === 1'b1; n = n + 1)
				@(posedge clk);
			chk("pulse", 8, n);
			@(posedge clk);
			bus(0, `OFS_RST_CAUSE, 0);
			chk("cause", c, rdata);
			bus(1, `OFS_RST_CAUSE, 32'h1f);
		end
	endtask
	// Cut a hang short
	initial begin
		#4000000;
		fail_count = fail_count + 1;
		close_out;
	end
	// Main sequence
	initial begin
		fail_count = 0;
		num_checks = 0;
		{nrst, read, write, sensor_out_of_range, sensor_fatal} = 0;
		{ram_read, ram_write, ee_write_active, ee_ecc_error} = 0;
		{fetch_compare_fail, bignum_access, cpu_mode, address} = 0;
		{writedata, ram_addr, ram_wdata} = 0;
		ee_hv_ok = 1;
		stack_pointer = 16'h80;
		repeat (2) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		t_ram;
		bus(0, `OFS_RST_CAUSE, 0);
		chk("power", 32'h1, rdata);
		bus(0, 4'hf, 0);
		chk("unmapped", 0, rdata);
		bus(1, `OFS_RST_CAUSE, 32'h1f);
		for (k = 0; k < 4; k = k + 1) t_exc(k);
		ee_write_active <= 1;
		ee_hv_ok <= 0;
		repeat (6) @(posedge clk);
		ee_write_active <= 0;
		ee_hv_ok <= 1;
		repeat (6) @(posedge clk);
		bus(0, `OFS_HV_STATUS, 0);
		chk("hv", 32'h2, rdata);
		chk("hv irq", 0, irq);
		bus(1, `OFS_CTRL, 32'h2);
		@(posedge clk);
		chk("dbl", 1, ee_double_read_en);
		t_rst(0, 32'h2);
		t_rst(1, 32'h10);
		t_rst(2, 32'h8);
		close_out;
	end
endmodule

// [pkg/fault_monitor_defines.vh]
// Register offsets, field positions, reset values and timing counts
`ifndef FAULT_MONITOR_DEFINES_VH
`define FAULT_MONITOR_DEFINES_VH

// Register word offsets
`define OFS_CTRL        4'h0
`define OFS_EXC_STATUS  4'h1
`define OFS_EXC_MASK    4'h2
`define OFS_RST_CAUSE   4'h3
`define OFS_HV_STATUS   4'h4
`define OFS_WDT_LOAD    4'h5
`define OFS_WDT_KICK    4'h6
`define OFS_SP_LOW      4'h7
`define OFS_SP_HIGH     4'h8
`define OFS_SCRUB_ADDR  4'h9

// Control register fields
`define CTRL_WDT_EN     0
`define CTRL_DBL_READ   1
`define CTRL_INV_ECC    2
`define CTRL_BIGNUM_OFF 3
`define CTRL_RESET      8'h00

// Exception status fields
`define EXC_SENSOR      0
`define EXC_STACK       1
`define EXC_ECC         2
`define EXC_BIGNUM      3
`define EXC_FETCH       4
`define EXC_WIDTH       5

// Reset cause fields
`define RC_POWER        0
`define RC_SENSOR       1
`define RC_PARITY       2
`define RC_WATCHDOG     3
`define RC_FETCH        4
`define RC_WIDTH        5

// Stack mode select
`define SP_USER         2'h0
`define SP_PRIV         2'h1
`define SP_BOOT         2'h2

// Reset values
`define WDT_LOAD_RESET  16'hffff
`define SP_LOW_RESET    16'h0000
`define SP_HIGH_RESET   16'hffff

// RAM geometry
`define RAM_AW          8
`define RAM_DW          8

// Reset pulse length in cycles
`define RST_PULSE       4'h8

`endif

// [src/fault_monitor_exception_reset.v]
// Fault supervision: sensors, RAM parity, stack limits, watchdog, causes
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "fault_monitor_defines.vh"

module fault_monitor_exception_reset (
	// Clock and reset
	input  wire        clk,
	input  wire        nrst,
	// Avalon-MM slave
	input  wire [3:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output reg         waitrequest,
	// Sensor inputs, asynchronous
	input  wire        sensor_out_of_range,
	input  wire        sensor_fatal,
	// CPU RAM port
	input  wire        ram_read,
	input  wire        ram_write,
	input  wire [7:0]  ram_addr,
	input  wire [7:0]  ram_wdata,
	output reg  [7:0]  ram_rdata,
	// Stack pointer
	input  wire [1:0]  cpu_mode,
	input  wire [15:0] stack_pointer,
	// EEPROM
	input  wire        ee_write_active,
	input  wire        ee_hv_ok,
	input  wire        ee_ecc_error,
	output reg         ee_double_read_en,
	// Checked fetch and coprocessor
	input  wire        fetch_compare_fail,
	input  wire        bignum_access,
	// Outputs to the system
	output reg         irq,
	output reg         security_reset
);

	// Synchronisers for pin-level inputs
	reg [1:0] s_oor_reg;
	reg [1:0] s_fat_reg;
	reg [1:0] s_hvw_reg;
	reg [1:0] s_hvok_reg;
	always @(posedge clk) begin
		if (!nrst) begin
			s_oor_reg  <= 2'h0;
			s_fat_reg  <= 2'h0;
			s_hvw_reg  <= 2'h0;
			s_hvok_reg <= 2'h0;
		end else begin
			s_oor_reg  <= {s_oor_reg[0], sensor_out_of_range};
			s_fat_reg  <= {s_fat_reg[0], sensor_fatal};
			s_hvw_reg  <= {s_hvw_reg[0], ee_write_active};
			s_hvok_reg <= {s_hvok_reg[0], ee_hv_ok};
		end
	end
	wire oor   = s_oor_reg[1];
	wire fatal = s_fat_reg[1];
	wire hv_w  = s_hvw_reg[1];
	wire hv_ok = s_hvok_reg[1];

	// Software registers
	reg [7:0]  ctrl_reg;
	reg [4:0]  exc_status_reg;
	reg [4:0]  exc_mask_reg;
	reg [4:0]  rst_cause_reg;
	reg [1:0]  hv_status_reg;
	reg [15:0] wdt_load_reg;
	reg [15:0] wdt_cnt_reg;
	reg [15:0] sp_low_reg  [0:2];
	reg [15:0] sp_high_reg [0:2];
	reg [3:0]  rst_pulse_reg;
	reg        pending_reset_reg;
	reg [4:0]  pending_cause_reg;

	// RAM with parity bit per word
	reg [8:0]  ram_mem [0:255];
	reg [7:0]  lfsr_reg;
	reg        rd_check_reg;
	reg [8:0]  rd_word_reg;
	reg        scrub_check_reg;
	reg [8:0]  scrub_word_reg;
	reg [7:0]  scrub_last_reg;
	reg        zero_slot_reg;

	wire bus_wr = write && !waitrequest;
	wire bus_rd = read && !waitrequest;

	// Parity of stored words
	wire rd_par_err    = rd_check_reg &&
		(^rd_word_reg[7:0] != rd_word_reg[8]);
	wire scrub_par_err = scrub_check_reg &&
		(^scrub_word_reg[7:0] != scrub_word_reg[8]);
	wire parity_err    = rd_par_err || scrub_par_err;

	// Per-mode stack limit checks
	wire [2:0] sp_viol;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sp
			localparam [1:0] MODE_SEL = gi;
			assign sp_viol[gi] = (cpu_mode == MODE_SEL) &&
				((stack_pointer < sp_low_reg[gi]) ||
				(stack_pointer > sp_high_reg[gi]));
		end
	endgenerate

	// Watchdog expiry
	wire wdt_en     = ctrl_reg[`CTRL_WDT_EN];
	wire wdt_expire = wdt_en && (wdt_cnt_reg == 16'h0000);

	// Exception events, sensors not maskable at source
	wire [4:0] exc_ev;
	assign exc_ev[`EXC_SENSOR] = oor;
	assign exc_ev[`EXC_STACK]  = |sp_viol;
	assign exc_ev[`EXC_ECC]    = ee_ecc_error &&
		ctrl_reg[`CTRL_INV_ECC];
	assign exc_ev[`EXC_BIGNUM] = bignum_access &&
		ctrl_reg[`CTRL_BIGNUM_OFF];
	assign exc_ev[`EXC_FETCH]  = fetch_compare_fail;

	// Reset events
	wire [4:0] rst_ev;
	assign rst_ev[`RC_POWER]    = 1'b0;
	assign rst_ev[`RC_SENSOR]   = fatal;
	assign rst_ev[`RC_PARITY]   = parity_err;
	assign rst_ev[`RC_WATCHDOG] = wdt_expire;
	assign rst_ev[`RC_FETCH]    = fetch_compare_fail;
	wire any_rst = |rst_ev;

	// Scrubber may use RAM only while CPU is idle
	wire cpu_ram = ram_read || ram_write;
	// Extra slot for the one address the LFSR never yields
	wire       scrub_gap  = (lfsr_reg == 8'h80) && !zero_slot_reg;
	wire [7:0] scrub_addr = scrub_gap ? 8'hff : (lfsr_reg ^ 8'hff);

	// RAM access, parity generation and scrubbing
	always @(posedge clk) begin
		if (ram_write) begin
			ram_mem[ram_addr] <= {^ram_wdata, ram_wdata};
		end
	end
	always @(posedge clk) begin
		if (!nrst) begin
			lfsr_reg        <= 8'h01;
			rd_check_reg    <= 1'b0;
			rd_word_reg     <= 9'h000;
			scrub_check_reg <= 1'b0;
			scrub_word_reg  <= 9'h000;
			scrub_last_reg  <= 8'h00;
			zero_slot_reg   <= 1'b0;
			ram_rdata       <= 8'h00;
		end else begin
			rd_check_reg <= ram_read;
			if (ram_read) begin
				rd_word_reg <= ram_mem[ram_addr];
				ram_rdata   <= ram_mem[ram_addr][7:0];
			end
			// Random visit order, LFSR plus zero slot
			scrub_check_reg <= !cpu_ram;
			if (!cpu_ram) begin
				scrub_word_reg <= ram_mem[scrub_addr];
				scrub_last_reg <= scrub_addr;
				zero_slot_reg  <= scrub_gap;
				if (!scrub_gap) begin
					lfsr_reg <= {lfsr_reg[6:0],
						lfsr_reg[7] ^ lfsr_reg[5] ^
						lfsr_reg[4] ^ lfsr_reg[3]};
				end
			end
		end
	end

	// Security reset pulse generation
	always @(posedge clk) begin
		if (!nrst) begin
			rst_pulse_reg     <= 4'h0;
			security_reset    <= 1'b0;
			pending_reset_reg <= 1'b0;
			pending_cause_reg <= 5'h00;
		end else begin
			if (any_rst && rst_pulse_reg == 4'h0) begin
				rst_pulse_reg     <= `RST_PULSE;
				security_reset    <= 1'b1;
				pending_reset_reg <= 1'b1;
				pending_cause_reg <= rst_ev;
			end else if (rst_pulse_reg != 4'h0) begin
				rst_pulse_reg  <= rst_pulse_reg - 4'h1;
				security_reset <= (rst_pulse_reg != 4'h1);
				if (rst_pulse_reg == 4'h1) begin
					pending_reset_reg <= 1'b0;
				end
			end
		end
	end

	// Register file and block state
	integer k;
	always @(posedge clk) begin
		if (!nrst) begin
			ctrl_reg       <= `CTRL_RESET;
			exc_status_reg <= 5'h00;
			exc_mask_reg   <= 5'h00;
			rst_cause_reg  <= 5'h01;
			hv_status_reg  <= 2'h0;
			wdt_load_reg   <= `WDT_LOAD_RESET;
			wdt_cnt_reg    <= `WDT_LOAD_RESET;
			for (k = 0; k < 3; k = k + 1) begin
				sp_low_reg[k]  <= `SP_LOW_RESET;
				sp_high_reg[k] <= `SP_HIGH_RESET;
			end
		end else if (pending_reset_reg) begin
			// Security reset returns all registers except rst_cause_reg to defaults; the cause is ORed in
			ctrl_reg       <= `CTRL_RESET;
			exc_status_reg <= 5'h00;
			exc_mask_reg   <= 5'h00;
			hv_status_reg  <= 2'h0;
			wdt_load_reg   <= `WDT_LOAD_RESET;
			wdt_cnt_reg    <= `WDT_LOAD_RESET;
			rst_cause_reg  <= rst_cause_reg | pending_cause_reg;
			for (k = 0; k < 3; k = k + 1) begin
				sp_low_reg[k]  <= `SP_LOW_RESET;
				sp_high_reg[k] <= `SP_HIGH_RESET;
			end
		end else begin
			// Sticky exception reasons, set wins over clear
			if (bus_wr && address == `OFS_EXC_STATUS) begin
				exc_status_reg <= (exc_status_reg &
					~writedata[4:0]) | exc_ev;
			end else begin
				exc_status_reg <= exc_status_reg | exc_ev;
			end
			// Reset cause cleared by writing ones
			if (bus_wr && address == `OFS_RST_CAUSE) begin
				rst_cause_reg <= rst_cause_reg &
					~writedata[4:0];
			end
			// Write voltage latched only, no event
			if (hv_w) begin
				hv_status_reg <= {1'b1, hv_ok};
			end else if (bus_wr && address == `OFS_HV_STATUS) begin
				hv_status_reg <= 2'h0;
			end
			if (bus_wr && address == `OFS_CTRL) begin
				ctrl_reg <= writedata[7:0];
			end
			if (bus_wr && address == `OFS_EXC_MASK) begin
				exc_mask_reg <= writedata[4:0];
			end
			if (bus_wr && address == `OFS_WDT_LOAD) begin
				wdt_load_reg <= writedata[15:0];
			end
			if (bus_wr && address == `OFS_SP_LOW &&
				writedata[17:16] != 2'h3) begin
				sp_low_reg[writedata[17:16]] <= writedata[15:0];
			end
			if (bus_wr && address == `OFS_SP_HIGH &&
				writedata[17:16] != 2'h3) begin
				sp_high_reg[writedata[17:16]] <= writedata[15:0];
			end
			// Watchdog count, reloaded by kick or while off
			if (!wdt_en || (bus_wr && address == `OFS_WDT_KICK)) begin
				wdt_cnt_reg <= wdt_load_reg;
			end else if (wdt_cnt_reg != 16'h0000) begin
				wdt_cnt_reg <= wdt_cnt_reg - 16'h0001;
			end
		end
	end

	// Bus answer: one wait cycle then data
	always @(posedge clk) begin
		if (!nrst) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h00000000;
		end else begin
			waitrequest <= !((read || write) && waitrequest);
			if (read && waitrequest) begin
				case (address)
				`OFS_CTRL:       readdata <= {24'h000000, ctrl_reg};
				`OFS_EXC_STATUS: readdata <= {27'h0, exc_status_reg};
				`OFS_EXC_MASK:   readdata <= {27'h0, exc_mask_reg};
				`OFS_RST_CAUSE:  readdata <= {27'h0, rst_cause_reg};
				`OFS_HV_STATUS:  readdata <= {30'h0, hv_status_reg};
				`OFS_WDT_LOAD:   readdata <= {16'h0000, wdt_load_reg};
				`OFS_WDT_KICK:   readdata <= {16'h0000, wdt_cnt_reg};
				`OFS_SP_LOW:     readdata <= {16'h0000, sp_low_reg[0]};
				`OFS_SP_HIGH:    readdata <= {16'h0000, sp_high_reg[0]};
				`OFS_SCRUB_ADDR: readdata <= {24'h000000, scrub_last_reg};
				default:         readdata <= 32'h00000000;
				endcase
			end else if (bus_rd) begin
				readdata <= readdata;
			end
		end
	end

	// Interrupt and EEPROM control outputs
	always @(posedge clk) begin
		if (!nrst) begin
			irq               <= 1'b0;
			ee_double_read_en <= 1'b0;
		end else begin
			irq <= |(exc_status_reg & exc_mask_reg);
			ee_double_read_en <= ctrl_reg[`CTRL_DBL_READ];
		end
	end

endmodule
